// File: inc/sp_pkg.sv
// Purpose: Shared constants and types of the asynchronous serial port.
// Assumes: 32-bit register port with byte addresses; 100 MHz system clock.
// Notes: Divisor reset value gives roughly 115200 baud at 100 MHz.
package sp_pkg;
   // Register byte addresses
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_DIV = 8'h04;
   localparam logic [7:0] A_TXDATA = 8'h08;
   localparam logic [7:0] A_BREAK = 8'h0C;
   localparam logic [7:0] A_RXDATA = 8'h10;
   localparam logic [7:0] A_STAT = 8'h14;
   localparam logic [7:0] A_MASK = 8'h18;
   localparam logic [7:0] A_GAP = 8'h1C;
   localparam logic [7:0] A_NODE = 8'h20;
   // Control fields
   localparam int C_EN = 0;
   localparam int C_WLEN = 1;
   localparam int C_PEN = 3;
   localparam int C_PODD = 4;
   localparam int C_MULTIDROP = 5;
   localparam int C_STOP = 6;
   localparam int C_FLOW = 8;
   localparam int C_RTSLVL = 12;
   localparam int CTRL_W = 16;
   // Data word fields
   localparam int D_ADR = 8;
   // Status: sticky events, then live flags
   localparam int S_RXRDY = 0;
   localparam int S_PERR = 1;
   localparam int S_FERR = 2;
   localparam int S_OVR = 3;
   localparam int S_BRK = 4;
   localparam int S_TXDONE = 5;
   localparam int EV_W = 6;
   localparam int S_TXFULL = 8;
   localparam int S_RXAVAIL = 9;
   // Reset values
   localparam logic [15:0] CTRL_RST = 16'h8006;
   localparam logic [15:0] DIV_RST = 16'h0364;
   localparam logic [7:0] GAP_RST = 8'h00;
   localparam logic [7:0] NODE_RST = 8'h00;
   localparam logic [5:0] MASK_RST = 6'h00;
   // FIFO sizes and base index of the last data bit
   localparam logic [2:0] TXF_DEPTH = 3'h4;
   localparam logic [3:0] RXF_DEPTH = 4'h8;
   localparam logic [2:0] LAST_BIT_BASE = 3'h4;

   typedef enum logic [2:0]
   {
      TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3, TX_ADDR = 3'h2,
      TX_PAR = 3'h6, TX_STOP = 3'h7, TX_GAP = 3'h5, TX_BRK = 3'h4
   } tx_state_e;

   typedef enum logic [2:0]
   {
      RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3, RX_ADDR = 3'h2,
      RX_PAR = 3'h6, RX_STOP = 3'h7, RX_WAIT = 3'h5
   } rx_state_e;
endpackage

// File: hw/pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for a pin.
// Assumes: Input is asynchronous to clk_sys.
// Notes: Output follows once stages two and three agree.
`timescale 1ns/1ps
module pin_sync
#(
   parameter logic RST_VAL = 1'b1
)
(
   input logic clk_sys,
   input logic rst,
   input logic din,
   output logic dout
);
   logic s1_ff, s2_ff, s3_ff, out_ff;
   logic nxt_out;

   always_comb
   begin
      nxt_out = (s2_ff == s3_ff) ? s3_ff : out_ff;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s1_ff <= RST_VAL;
         s2_ff <= RST_VAL;
         s3_ff <= RST_VAL;
         out_ff <= RST_VAL;
      end
      else
      begin
         s1_ff <= din;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         out_ff <= nxt_out;
      end
   end

   assign dout = out_ff;
endmodule

// File: hw/async_serial_port.sv
// Purpose: One full-duplex asynchronous serial port with register port.
// Assumes: The chip places three of these side by side.
// Notes: Break and data share the transmit queue, so order is kept.
// How it works
// - Three independent ports, each sending and receiving at once.
// - Data paths serviced by processor or DMA via request levels.
// - Five to eight data bits per character, same on both ends.
// - Parity none, even or odd; sent by transmitter, checked by receiver.
// - Multidrop adds address bit; only addressed frames and line breaks raise receive events.
// - Each sent frame ends with programmable count of stop bits.
// - With flow control, new characters start only while clear-to-send.
// - With flow control, request-to-send follows receive FIFO threshold.
// - Break command queued in order, holds line low programmable bits.
// - Optional programmable idle gap after each frame's stop bits.
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module async_serial_port
(
   input logic clk_sys,
   input logic rst,
   input logic [7:0] addr,
   input logic [31:0] wdata,
   input logic wr,
   input logic rd,
   output logic [31:0] rdata,
   output logic txd,
   input logic rxd,
   input logic cts,
   output logic rts,
   output logic irq,
   output logic tx_dma_req,
   output logic rx_dma_req
);
   logic [15:0] ctrl_ff, nxt_ctrl, div_ff, nxt_div, tx_baud_ff, nxt_tx_baud;
   logic [15:0] rx_baud_ff, nxt_rx_baud, div_m1;
   logic [7:0] gap_ff, nxt_gap, node_ff, nxt_node, tx_idx_ff, nxt_tx_idx;
   logic [5:0] mask_ff, nxt_mask, stat_ff, nxt_stat, ev, clr;
   logic [4:0] rx_ev;
   logic tx_done_ev;
   logic [31:0] rdata_ff, nxt_rdata;
   logic irq_ff, nxt_irq, rts_ff, nxt_rts, txd_ff, nxt_txd;
   logic txdreq_ff, nxt_txdreq, rxdreq_ff, nxt_rxdreq;
   logic [9:0] txf_mem [4];
   logic [8:0] rxf_mem [8];
   logic [1:0] txf_wp_ff, nxt_txf_wp, txf_rp_ff, nxt_txf_rp;
   logic [2:0] txf_cnt_ff, nxt_txf_cnt, rxf_wp_ff, nxt_rxf_wp, rxf_rp_ff, nxt_rxf_rp;
   logic [3:0] rxf_cnt_ff, nxt_rxf_cnt;
   logic [9:0] tx_sh_ff, nxt_tx_sh, tx_in;
   logic [7:0] rx_sh_ff, nxt_rx_sh, rx_data, wmask;
   logic [2:0] rx_idx_ff, nxt_rx_idx, last_bit;
   logic rx_adr_ff, nxt_rx_adr, rx_perr_ff, nxt_rx_perr, rx_sel_ff, nxt_rx_sel;
   logic tx_push, tx_pop, rx_push, rx_pop, tx_tick, rx_tick, par_bit, rx_s, cts_s;
   logic rx_stop_done;
   logic [1:0] wlen;
   sp_pkg::tx_state_e tx_st_ff, nxt_tx_st;
   sp_pkg::rx_state_e rx_st_ff, nxt_rx_st;

   pin_sync #(.RST_VAL(1'b1)) u_rx_sync
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .din(rxd),
      .dout(rx_s)
   );

   pin_sync #(.RST_VAL(1'b0)) u_cts_sync
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .din(cts),
      .dout(cts_s)
   );

   // Shared framing helpers
   always_comb
   begin
      wlen = ctrl_ff[sp_pkg::C_WLEN +: 2];
      last_bit = {1'b0, wlen} + sp_pkg::LAST_BIT_BASE;
      wmask = 8'hFF >> (2'h3 - wlen);
      div_m1 = (div_ff == 16'h0000) ? 16'h0000 : div_ff - 16'h0001;
      tx_tick = (tx_baud_ff >= div_m1);
      rx_tick = (rx_baud_ff >= div_m1);
      par_bit = (^(tx_sh_ff[7:0] & wmask)) ^ ctrl_ff[sp_pkg::C_PODD];
      rx_data = rx_sh_ff >> (2'h3 - wlen);
   end

   // Register port, status and interrupt
   always_comb
   begin
      nxt_ctrl = ctrl_ff;
      nxt_div = div_ff;
      nxt_mask = mask_ff;
      nxt_gap = gap_ff;
      nxt_node = node_ff;
      if (wr)
      begin
         case (addr)
            sp_pkg::A_CTRL: nxt_ctrl = wdata[15:0];
            sp_pkg::A_DIV: nxt_div = wdata[15:0];
            sp_pkg::A_MASK: nxt_mask = wdata[5:0];
            sp_pkg::A_GAP: nxt_gap = wdata[7:0];
            sp_pkg::A_NODE: nxt_node = wdata[7:0];
            default: nxt_ctrl = ctrl_ff;
         endcase
      end
      ev = {tx_done_ev, rx_ev};
      clr = (wr && addr == sp_pkg::A_STAT) ? wdata[5:0] : 6'h00;
      nxt_stat = (stat_ff & ~clr) | ev;
      nxt_irq = |(nxt_stat & nxt_mask);
      nxt_rdata = 32'h0000_0000;
      if (rd)
      begin
         case (addr)
            sp_pkg::A_CTRL: nxt_rdata = {16'h0000, ctrl_ff};
            sp_pkg::A_DIV: nxt_rdata = {16'h0000, div_ff};
            sp_pkg::A_RXDATA: nxt_rdata = (rxf_cnt_ff != 4'h0) ? {23'h0, rxf_mem[rxf_rp_ff]} : 32'h0;
            sp_pkg::A_STAT: nxt_rdata = {22'h0, rxf_cnt_ff != 4'h0,
               txf_cnt_ff == sp_pkg::TXF_DEPTH, 2'h0, stat_ff};
            sp_pkg::A_MASK: nxt_rdata = {26'h0, mask_ff};
            sp_pkg::A_GAP: nxt_rdata = {24'h0, gap_ff};
            sp_pkg::A_NODE: nxt_rdata = {24'h0, node_ff};
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   // Queues, flow control and DMA requests
   always_comb
   begin
      tx_push = wr && (addr == sp_pkg::A_TXDATA || addr == sp_pkg::A_BREAK)
         && txf_cnt_ff != sp_pkg::TXF_DEPTH;
      tx_in = (addr == sp_pkg::A_BREAK) ? {2'b10, wdata[7:0]} : {1'b0, wdata[8:0]};
      rx_pop = rd && addr == sp_pkg::A_RXDATA && rxf_cnt_ff != 4'h0;
      nxt_txf_wp = tx_push ? txf_wp_ff + 2'h1 : txf_wp_ff;
      nxt_txf_rp = tx_pop ? txf_rp_ff + 2'h1 : txf_rp_ff;
      nxt_txf_cnt = txf_cnt_ff + {2'h0, tx_push} - {2'h0, tx_pop};
      nxt_rxf_wp = (rx_push && rxf_cnt_ff != sp_pkg::RXF_DEPTH) ? rxf_wp_ff + 3'h1 : rxf_wp_ff;
      nxt_rxf_rp = rx_pop ? rxf_rp_ff + 3'h1 : rxf_rp_ff;
      nxt_rxf_cnt = rxf_cnt_ff + {3'h0, nxt_rxf_wp != rxf_wp_ff} - {3'h0, rx_pop};
      nxt_rts = !ctrl_ff[sp_pkg::C_FLOW] || (rxf_cnt_ff < ctrl_ff[sp_pkg::C_RTSLVL +: 4]);
      nxt_txdreq = nxt_txf_cnt != sp_pkg::TXF_DEPTH;
      nxt_rxdreq = nxt_rxf_cnt != 4'h0;
   end

   // Transmitter, independent of the receiver
   always_comb
   begin
      nxt_tx_st = tx_st_ff;
      nxt_tx_baud = tx_tick ? 16'h0000 : tx_baud_ff + 16'h0001;
      nxt_tx_idx = tx_idx_ff;
      nxt_tx_sh = tx_sh_ff;
      nxt_txd = txd_ff;
      tx_pop = 1'b0;
      tx_done_ev = 1'b0;
      case (tx_st_ff)
         sp_pkg::TX_IDLE:
         begin
            nxt_tx_baud = 16'h0000;
            nxt_txd = 1'b1;
            if (ctrl_ff[sp_pkg::C_EN] && txf_cnt_ff != 3'h0
               && (!ctrl_ff[sp_pkg::C_FLOW] || cts_s))
            begin
               tx_pop = 1'b1;
               nxt_tx_sh = txf_mem[txf_rp_ff];
               nxt_txd = 1'b0;
               if (txf_mem[txf_rp_ff][9])
               begin
                  nxt_tx_st = sp_pkg::TX_BRK;
                  nxt_tx_idx = (txf_mem[txf_rp_ff][7:0] == 8'h00) ? 8'h00
                     : txf_mem[txf_rp_ff][7:0] - 8'h01;
               end
               else
               begin
                  nxt_tx_st = sp_pkg::TX_START;
               end
            end
         end
         sp_pkg::TX_START:
         begin
            if (tx_tick)
            begin
               nxt_tx_st = sp_pkg::TX_DATA;
               nxt_tx_idx = 8'h00;
               nxt_txd = tx_sh_ff[0];
            end
         end
         sp_pkg::TX_DATA:
         begin
            if (tx_tick)
            begin
               if (tx_idx_ff[2:0] == last_bit)
               begin
                  if (ctrl_ff[sp_pkg::C_MULTIDROP])
                  begin
                     nxt_tx_st = sp_pkg::TX_ADDR;
                     nxt_txd = tx_sh_ff[sp_pkg::D_ADR];
                  end
                  else if (ctrl_ff[sp_pkg::C_PEN])
                  begin
                     nxt_tx_st = sp_pkg::TX_PAR;
                     nxt_txd = par_bit;
                  end
                  else
                  begin
                     nxt_tx_st = sp_pkg::TX_STOP;
                     nxt_tx_idx = 8'h00;
                     nxt_txd = 1'b1;
                  end
               end
               else
               begin
                  nxt_tx_idx = tx_idx_ff + 8'h01;
                  nxt_txd = tx_sh_ff[tx_idx_ff[2:0] + 3'h1];
               end
            end
         end
         sp_pkg::TX_ADDR:
         begin
            if (tx_tick)
            begin
               nxt_tx_st = ctrl_ff[sp_pkg::C_PEN] ? sp_pkg::TX_PAR : sp_pkg::TX_STOP;
               nxt_tx_idx = 8'h00;
               nxt_txd = ctrl_ff[sp_pkg::C_PEN] ? par_bit : 1'b1;
            end
         end
         sp_pkg::TX_PAR:
         begin
            if (tx_tick)
            begin
               nxt_tx_st = sp_pkg::TX_STOP;
               nxt_tx_idx = 8'h00;
               nxt_txd = 1'b1;
            end
         end
         sp_pkg::TX_STOP:
         begin
            if (tx_tick)
            begin
               if (tx_idx_ff[1:0] == ctrl_ff[sp_pkg::C_STOP +: 2])
               begin
                  nxt_tx_idx = 8'h00;
                  nxt_tx_st = (gap_ff != 8'h00) ? sp_pkg::TX_GAP : sp_pkg::TX_IDLE;
                  tx_done_ev = (gap_ff == 8'h00);
               end
               else
               begin
                  nxt_tx_idx = tx_idx_ff + 8'h01;
               end
            end
         end
         sp_pkg::TX_GAP:
         begin
            if (tx_tick)
            begin
               if (tx_idx_ff == gap_ff - 8'h01)
               begin
                  nxt_tx_st = sp_pkg::TX_IDLE;
                  tx_done_ev = 1'b1;
               end
               else
               begin
                  nxt_tx_idx = tx_idx_ff + 8'h01;
               end
            end
         end
         sp_pkg::TX_BRK:
         begin
            if (tx_tick)
            begin
               if (tx_idx_ff == 8'h00)
               begin
                  nxt_tx_st = sp_pkg::TX_STOP;
                  nxt_txd = 1'b1;
               end
               else
               begin
                  nxt_tx_idx = tx_idx_ff - 8'h01;
               end
            end
         end
         default: nxt_tx_st = sp_pkg::TX_IDLE;
      endcase
   end

   // Receiver, samples mid-bit
   always_comb
   begin
      nxt_rx_st = rx_st_ff;
      nxt_rx_baud = rx_tick ? 16'h0000 : rx_baud_ff + 16'h0001;
      nxt_rx_idx = rx_idx_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_rx_adr = rx_adr_ff;
      nxt_rx_perr = rx_perr_ff;
      nxt_rx_sel = rx_sel_ff;
      rx_push = 1'b0;
      rx_stop_done = 1'b0;
      rx_ev = 5'h00;
      case (rx_st_ff)
         sp_pkg::RX_IDLE:
         begin
            nxt_rx_baud = 16'h0000;
            nxt_rx_adr = 1'b0;
            nxt_rx_perr = 1'b0;
            if (ctrl_ff[sp_pkg::C_EN] && !rx_s)
            begin
               nxt_rx_st = sp_pkg::RX_START;
            end
         end
         sp_pkg::RX_START:
         begin
            if (rx_baud_ff >= (div_m1 >> 1))
            begin
               nxt_rx_baud = 16'h0000;
               nxt_rx_idx = 3'h0;
               nxt_rx_st = rx_s ? sp_pkg::RX_IDLE : sp_pkg::RX_DATA;
            end
         end
         sp_pkg::RX_DATA:
         begin
            if (rx_tick)
            begin
               nxt_rx_sh = {rx_s, rx_sh_ff[7:1]};
               nxt_rx_idx = rx_idx_ff + 3'h1;
               if (rx_idx_ff == last_bit)
               begin
                  nxt_rx_st = ctrl_ff[sp_pkg::C_MULTIDROP] ? sp_pkg::RX_ADDR
                     : ctrl_ff[sp_pkg::C_PEN] ? sp_pkg::RX_PAR : sp_pkg::RX_STOP;
               end
            end
         end
         sp_pkg::RX_ADDR:
         begin
            if (rx_tick)
            begin
               nxt_rx_adr = rx_s;
               nxt_rx_st = ctrl_ff[sp_pkg::C_PEN] ? sp_pkg::RX_PAR : sp_pkg::RX_STOP;
            end
         end
         sp_pkg::RX_PAR:
         begin
            if (rx_tick)
            begin
               nxt_rx_perr = rx_s != ((^rx_data) ^ ctrl_ff[sp_pkg::C_PODD]);
               nxt_rx_st = sp_pkg::RX_STOP;
            end
         end
         sp_pkg::RX_STOP:
         begin
            if (rx_tick)
            begin
               rx_stop_done = 1'b1;
               nxt_rx_st = rx_s ? sp_pkg::RX_IDLE : sp_pkg::RX_WAIT;
               // Short words leave stale bits low in the shifter
               if (!rx_s && rx_data == 8'h00 && !rx_adr_ff)
               begin
                  rx_ev[sp_pkg::S_BRK] = 1'b1;
               end
               else
               begin
                  if (ctrl_ff[sp_pkg::C_MULTIDROP] && rx_adr_ff)
                  begin
                     nxt_rx_sel = (rx_data == node_ff);
                  end
                  rx_push = !ctrl_ff[sp_pkg::C_MULTIDROP] || nxt_rx_sel;
                  rx_ev[sp_pkg::S_RXRDY] = rx_push;
                  rx_ev[sp_pkg::S_PERR] = rx_push && ctrl_ff[sp_pkg::C_PEN] && rx_perr_ff;
                  rx_ev[sp_pkg::S_FERR] = rx_push && !rx_s;
                  rx_ev[sp_pkg::S_OVR] = rx_push && rxf_cnt_ff == sp_pkg::RXF_DEPTH;
               end
            end
         end
         sp_pkg::RX_WAIT:
         begin
            if (rx_s)
            begin
               nxt_rx_st = sp_pkg::RX_IDLE;
            end
         end
         default: nxt_rx_st = sp_pkg::RX_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ctrl_ff <= sp_pkg::CTRL_RST;
         div_ff <= sp_pkg::DIV_RST;
         mask_ff <= sp_pkg::MASK_RST;
         gap_ff <= sp_pkg::GAP_RST;
         node_ff <= sp_pkg::NODE_RST;
         stat_ff <= 6'h00;
         rdata_ff <= 32'h0000_0000;
         irq_ff <= 1'b0;
         rts_ff <= 1'b0;
         txdreq_ff <= 1'b0;
         rxdreq_ff <= 1'b0;
         txf_wp_ff <= 2'h0;
         txf_rp_ff <= 2'h0;
         txf_cnt_ff <= 3'h0;
         rxf_wp_ff <= 3'h0;
         rxf_rp_ff <= 3'h0;
         rxf_cnt_ff <= 4'h0;
         tx_st_ff <= sp_pkg::TX_IDLE;
         tx_baud_ff <= 16'h0000;
         tx_idx_ff <= 8'h00;
         tx_sh_ff <= 10'h000;
         txd_ff <= 1'b1;
         rx_st_ff <= sp_pkg::RX_IDLE;
         rx_baud_ff <= 16'h0000;
         rx_idx_ff <= 3'h0;
         rx_sh_ff <= 8'h00;
         rx_adr_ff <= 1'b0;
         rx_perr_ff <= 1'b0;
         rx_sel_ff <= 1'b0;
      end
      else
      begin
         ctrl_ff <= nxt_ctrl;
         div_ff <= nxt_div;
         mask_ff <= nxt_mask;
         gap_ff <= nxt_gap;
         node_ff <= nxt_node;
         stat_ff <= nxt_stat;
         rdata_ff <= nxt_rdata;
         irq_ff <= nxt_irq;
         rts_ff <= nxt_rts;
         txdreq_ff <= nxt_txdreq;
         rxdreq_ff <= nxt_rxdreq;
         txf_wp_ff <= nxt_txf_wp;
         txf_rp_ff <= nxt_txf_rp;
         txf_cnt_ff <= nxt_txf_cnt;
         rxf_wp_ff <= nxt_rxf_wp;
         rxf_rp_ff <= nxt_rxf_rp;
         rxf_cnt_ff <= nxt_rxf_cnt;
         tx_st_ff <= nxt_tx_st;
         tx_baud_ff <= nxt_tx_baud;
         tx_idx_ff <= nxt_tx_idx;
         tx_sh_ff <= nxt_tx_sh;
         txd_ff <= nxt_txd;
         rx_st_ff <= nxt_rx_st;
         rx_baud_ff <= nxt_rx_baud;
         rx_idx_ff <= nxt_rx_idx;
         rx_sh_ff <= nxt_rx_sh;
         rx_adr_ff <= nxt_rx_adr;
         rx_perr_ff <= nxt_rx_perr;
         rx_sel_ff <= nxt_rx_sel;
      end
   end

   // Queue storage, no reset needed
   always_ff @(posedge clk_sys)
   begin
      if (tx_push)
         txf_mem[txf_wp_ff] <= tx_in;
      if (rx_push && rxf_cnt_ff != sp_pkg::RXF_DEPTH)
         rxf_mem[rxf_wp_ff] <= {rx_adr_ff, rx_data};
   end

   assign rdata = rdata_ff;
   assign txd = txd_ff;
   assign rts = rts_ff;
   assign irq = irq_ff;
   assign tx_dma_req = txdreq_ff;
   assign rx_dma_req = rxdreq_ff;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence brk_end_s;
      tx_st_ff == sp_pkg::TX_BRK && tx_tick && tx_idx_ff == 8'h00;
   endsequence

   start_low_a: assert property (tx_st_ff == sp_pkg::TX_START |-> !txd_ff)
      else $error("start bit not low");
   cts_gate_a: assert property (tx_st_ff == sp_pkg::TX_IDLE && nxt_tx_st != sp_pkg::TX_IDLE
      |-> !ctrl_ff[sp_pkg::C_FLOW] || cts_s)
      else $error("frame started without clear-to-send");
   stop_high_a: assert property (tx_st_ff == sp_pkg::TX_STOP |-> txd_ff)
      else $error("stop bit not high");
   break_end_a: assert property (brk_end_s |=> tx_st_ff == sp_pkg::TX_STOP && txd_ff)
      else $error("break did not end in stop");
   gap_idle_a: assert property (tx_st_ff == sp_pkg::TX_GAP |-> txd_ff && gap_ff != 8'h00)
      else $error("gap not idle high");
   tx_parity_a: assert property (tx_st_ff == sp_pkg::TX_PAR |-> txd_ff == par_bit)
      else $error("parity bit wrong");
   char_len_a: assert property (tx_st_ff == sp_pkg::TX_DATA && tx_tick
      && tx_idx_ff[2:0] == last_bit |=> tx_st_ff != sp_pkg::TX_DATA)
      else $error("character length wrong");
   rts_level_a: assert property (ctrl_ff[sp_pkg::C_FLOW]
      && rxf_cnt_ff >= ctrl_ff[sp_pkg::C_RTSLVL +: 4] |=> !rts_ff)
      else $error("rts not dropped at threshold");
   overrun_flag_a: assert property (rx_push && rxf_cnt_ff == sp_pkg::RXF_DEPTH
      |=> stat_ff[sp_pkg::S_OVR])
      else $error("overrun not flagged");
   drop_quiet_a: assert property (rx_stop_done && ctrl_ff[sp_pkg::C_MULTIDROP] && !rx_adr_ff
      && !rx_sel_ff |-> !rx_push ##1 !$rose(stat_ff[sp_pkg::S_RXRDY]))
      else $error("unaddressed frame delivered");
endmodule

// File: verif/serial_node.sv
// Purpose: Remote serial node model facing the port's line pins.
// Assumes: Bit time of BIT_CLKS system clocks; idle line high.
// Notes: Sends and captures frames bit by bit; line idles high between frames.
`timescale 1ns/1ps
module serial_node
#(
   parameter int BIT_CLKS = 8
)
(
   input wire logic clk_sys,
   input wire logic line_in,
   output logic line_out
);
   initial line_out = 1'b1;
   // Frame bits are given start first; caller builds parity and stops
   task automatic send(input logic [15:0] bits, input int n);
      for (int i = 0; i < n; i++)
      begin
         line_out <= bits[i];
         repeat (BIT_CLKS) @(posedge clk_sys);
      end
      line_out <= 1'b1;
      repeat (BIT_CLKS) @(posedge clk_sys);
   endtask
   // Samples mid-bit from the first falling edge
   task automatic grab(input int n, output logic [15:0] bits);
      bits = '0;
      @(negedge line_in);
      repeat (BIT_CLKS / 2) @(posedge clk_sys);
      for (int i = 0; i < n; i++)
      begin
         bits[i] = line_in;
         repeat (BIT_CLKS) @(posedge clk_sys);
      end
   endtask
endmodule

// File: verif/tb_async_serial_port.sv
// Purpose: Self-checking bench for one serial port.
// Assumes: Divisor set to 8 clocks per bit to keep the run short.
// Notes: Far side is the serial_node model; cts driven here.
`timescale 1ns/1ps
module tb_async_serial_port;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic cts = 1'b1;
   logic [31:0] rdata;
   logic txd, rxd, rts, irq, tx_dma_req, rx_dma_req;
   int n_fail = 0;
   int checked = 0;
   int cycles = 0;
   logic [15:0] bits;
   logic [31:0] rv;
   always #5 clk_sys = ~clk_sys;
   async_serial_port dut_u (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .txd(txd), .rxd(rxd), .cts(cts), .rts(rts),
      .irq(irq), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
   serial_node #(.BIT_CLKS(8)) node_u (.clk_sys(clk_sys), .line_in(txd), .line_out(rxd));
   task automatic report_and_stop();
      $display("checks %0d failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_fail = n_fail + 1;
         report_and_stop();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd_reg(input logic [7:0] a);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 rv = rdata;
      @(posedge clk_sys);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      rd_reg(a);
      chk(what, exp, rv);
   endtask
   // Sets control, queues one word and captures n line bits
   task automatic tx_chk(input logic [31:0] c, input logic [8:0] d, input int n,
      input logic [15:0] exp, input string what);
      wr_reg(sp_pkg::A_CTRL, c);
      fork
         wr_reg(sp_pkg::A_TXDATA, {23'h0, d});
         node_u.grab(n, bits);
      join
      chk(what, {16'h0, exp}, {16'h0, bits});
   endtask
   initial
   begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd_chk(sp_pkg::A_CTRL, 32'h00008006, "ctrl reset");
      rd_chk(sp_pkg::A_DIV, 32'h00000364, "div reset");
      rd_chk(8'h3C, 32'h0, "unmapped");
      wr_reg(sp_pkg::A_DIV, 32'h8);
      tx_chk(32'h00008007, 9'h055, 10, 16'h02AA, "tx 8n1");
      tx_chk(32'h00008059, 9'h013, 10, 16'h03A6, "tx 5o2");
      tx_chk(32'h0000800D, 9'h007, 10, 16'h030E, "tx 7e1");
      cts <= 1'b0;
      wr_reg(sp_pkg::A_CTRL, 32'h00008007);
      fork
         wr_reg(sp_pkg::A_BREAK, 32'h3);
         node_u.grab(4, bits);
      join
      chk("break", 32'h8, {16'h0, bits});
      wr_reg(sp_pkg::A_GAP, 32'h2);
      fork
         begin
            wr_reg(sp_pkg::A_TXDATA, 32'hF0);
            wr_reg(sp_pkg::A_TXDATA, 32'hF0);
         end
         node_u.grab(13, bits);
      join
      chk("gap", 32'hFE0, {16'h0, bits});
      wr_reg(sp_pkg::A_GAP, 32'h0);
      repeat (80) @(posedge clk_sys);
      wr_reg(sp_pkg::A_CTRL, 32'h00002107);
      wr_reg(sp_pkg::A_TXDATA, 32'hFF);
      repeat (60) @(posedge clk_sys);
      chk("txd held", 32'h1, {31'h0, txd});
      cts <= 1'b1;
      node_u.grab(10, bits);
      chk("tx after cts", 32'h3FE, {16'h0, bits});
      repeat (20) @(posedge clk_sys);
      wr_reg(sp_pkg::A_STAT, 32'h3F);
      chk("rts open", 32'h1, {31'h0, rts});
      node_u.send(16'h0346, 10);
      node_u.send(16'h02B8, 10);
      chk("rts full", 32'h0, {31'h0, rts});
      chk("rx dma", 32'h1, {31'h0, rx_dma_req});
      rd_chk(sp_pkg::A_STAT, 32'h00000201, "stat rx");
      rd_chk(sp_pkg::A_RXDATA, 32'h000000A3, "rx first");
      rd_chk(sp_pkg::A_RXDATA, 32'h0000005C, "rx second");
      @(posedge clk_sys);
      chk("rts again", 32'h1, {31'h0, rts});
      chk("rx dma idle", 32'h0, {31'h0, rx_dma_req});
      wr_reg(sp_pkg::A_NODE, 32'h5A);
      wr_reg(sp_pkg::A_CTRL, 32'h00008027);
      wr_reg(sp_pkg::A_STAT, 32'h3F);
      node_u.send(16'h0666, 11);
      node_u.send(16'h0422, 11);
      rd_chk(sp_pkg::A_STAT, 32'h0, "drop quiet");
      node_u.send(16'h06B4, 11);
      node_u.send(16'h0444, 11);
      rd_chk(sp_pkg::A_RXDATA, 32'h15A, "rx own addr");
      rd_chk(sp_pkg::A_RXDATA, 32'h022, "rx own data");
      wr_reg(sp_pkg::A_STAT, 32'h3F);
      wr_reg(sp_pkg::A_CTRL, 32'h0000800F);
      wr_reg(sp_pkg::A_MASK, 32'h12);
      node_u.send(16'h0402, 11);
      rd_reg(sp_pkg::A_STAT);
      chk("parity flag", 32'h1, {31'h0, rv[sp_pkg::S_PERR]});
      chk("irq set", 32'h1, {31'h0, irq});
      wr_reg(sp_pkg::A_STAT, 32'h02);
      chk("irq clear", 32'h0, {31'h0, irq});
      node_u.send(16'h0000, 13);
      rd_reg(sp_pkg::A_STAT);
      chk("break flag", 32'h1, {31'h0, rv[sp_pkg::S_BRK]});
      chk("irq break", 32'h1, {31'h0, irq});
      cts <= 1'b0;
      repeat (8) node_u.send(16'h0400, 11);
      rd_reg(sp_pkg::A_STAT);
      chk("overrun", 32'h1, {31'h0, rv[sp_pkg::S_OVR]});
      wr_reg(sp_pkg::A_CTRL, 32'h0000810F);
      repeat (4) wr_reg(sp_pkg::A_TXDATA, 32'h55);
      chk("tx dma full", 32'h0, {31'h0, tx_dma_req});
      rd_reg(sp_pkg::A_STAT);
      chk("tx full", 32'h1, {31'h0, rv[sp_pkg::S_TXFULL]});
      report_and_stop();
   end
endmodule
